// File: wdtpm_top.sv
// watchdog timer, power modes and external reset filter
//
// Contract
// - after any reset watchdog disabled, timer and prescaler cleared
// - control bit 7 enables counting and time-out reset
// - writing restart bit 6 clears timer, prescaler and bit next cycle
// - control bit 5 keeps watchdog counting in idle; reset value zero
// - bits 2..0 pick ratio 2,4,8,16,32,64,128,256 in odd code order
// - time-out equals 2^14 times ratio times 12 oscillator periods
// - time-out while enabled produces full system reset
// - idle request stops processor clock only; interrupt or reset ends idle
// - power-down stops every clock; reset or enabled port interrupt wakes
// - reset pin sampled at state5 phase2, must stand two machine cycles; in power-down a high pin acts at once
// - reset loads zero into registers, power control bit 4 kept; power-on reset clears bit 4 as well
//
// Decided for this implementation: strobed register access.
module wdtpm_top
   import wdtpm_pkg::*;
#(
   parameter int PHASES = WDTPM_MACHINE_OSC   // oscillator clocks per machine cycle
) (
   input wire logic clk,                      // oscillator clock
   input wire logic rst,                      // power-on reset, active high
   input wire logic ext_reset_pin,            // external reset pin, active high
   input wire logic [7:0] wake_irq,           // enabled port 1 interrupts 2..9
   input wire logic any_irq,                  // any accepted interrupt
   input wire logic [7:0] addr,               // register address
   input wire logic [7:0] wdata,              // write data
   input wire logic wr,                       // write strobe
   input wire logic rd,                       // read strobe
   output logic [7:0] rdata,                  // read data, one cycle after rd
   output logic sys_reset,                    // full system reset out
   output logic cpu_clk_en,                   // processor clock gate
   output logic periph_clk_en,                // peripheral clock gate
   output logic [13:0] wdog_count             // timer value
);
   import wdtpm_pkg::*;

   localparam int PH_W = $clog2(PHASES);

   wdtpm_mode_t mode_q;
   logic [7:0] ctrl_q;
   logic [7:0] power_control_q;
   logic [PH_W-1:0] phase_q;
   logic [7:0] presc_q;
   logic [WDTPM_TIMER_W-1:0] timer_q;
   logic [1:0] pin_cnt_q;
   logic pin_reset_q;
   logic wdog_fire_q;
   logic sreset;
   logic mc_tick;
   logic clocks_on;
   logic counting;
   logic presc_tc;
   logic restart_pend;
   logic pd_wake;
   logic sample_now;
   logic [23:0] span_q;
   logic span_valid_q;

   // ratio select: code to ratio minus one, note swapped bits for codes 1 and 2
   function automatic logic [7:0] wdtpm_ratio_m1(input logic [2:0] sel);
      case (sel)
         3'h0: wdtpm_ratio_m1 = 8'h01;
         3'h2: wdtpm_ratio_m1 = 8'h03;
         3'h1: wdtpm_ratio_m1 = 8'h07;
         3'h3: wdtpm_ratio_m1 = 8'h0f;
         3'h4: wdtpm_ratio_m1 = 8'h1f;
         3'h5: wdtpm_ratio_m1 = 8'h3f;
         3'h6: wdtpm_ratio_m1 = 8'h7f;
         default: wdtpm_ratio_m1 = 8'hff;
      endcase
   endfunction : wdtpm_ratio_m1

   // any reset source restores mode, control and counts; phase, pin filter and power control bit 4 clear on power-on only
   assign sreset = rst | pin_reset_q | wdog_fire_q;
   assign sys_reset = sreset;
   assign clocks_on = (mode_q != WDTPM_PDOWN);
   assign cpu_clk_en = (mode_q == WDTPM_RUN);
   assign periph_clk_en = clocks_on;
   assign mc_tick = clocks_on && (phase_q == PH_W'(PHASES - 1));
   assign restart_pend = ctrl_q[WDTPM_BIT_RESTART];
   // idle only counts when allowed; power-down halts everything
   assign counting = ctrl_q[WDTPM_BIT_RUN] && clocks_on &&
                     (mode_q == WDTPM_RUN || ctrl_q[WDTPM_BIT_IDLE_RUN]);
   assign presc_tc = presc_q == wdtpm_ratio_m1(ctrl_q[2:0]);
   assign pd_wake = |wake_irq;
   // the reset pin is sampled once per machine cycle while the oscillator runs; in power-down a high pin acts at once
   assign sample_now = clocks_on && (phase_q == PH_W'(WDTPM_SAMPLE_PHASE % PHASES));
   assign wdog_count = timer_q;

   // machine-cycle phase counter, stopped with the oscillator
   // only power-on clears it: a held pin reset must keep being sampled to end
   always_ff @(posedge clk) begin
      if (rst) begin
         phase_q <= '0;
      end else if (clocks_on) begin
         phase_q <= mc_tick ? '0 : phase_q + PH_W'(1);
      end
   end

   // reset pin filter: sampled once a machine cycle, two in a row needed
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_cnt_q <= 2'h0;
         pin_reset_q <= 1'b0;
      end else if (sample_now) begin
         if (!ext_reset_pin) begin
            pin_cnt_q <= 2'h0;
            pin_reset_q <= 1'b0;
         end else if (pin_cnt_q == 2'(WDTPM_RST_HOLD_MC - 1)) begin
            pin_reset_q <= 1'b1;
         end else begin
            pin_cnt_q <= pin_cnt_q + 2'h1;
         end
      end else if (!clocks_on && ext_reset_pin) begin
         pin_reset_q <= 1'b1;   // hardware reset wakes power-down
      end
   end

   // power mode state; interrupts end idle, enabled port irqs end power-down
   always_ff @(posedge clk) begin
      if (sreset) begin
         mode_q <= WDTPM_RUN;
      end else begin
         case (mode_q)
            WDTPM_RUN: begin
               if (wr && addr == WDTPM_POWER_CONTROL_ADDR && wdata[WDTPM_BIT_PD]) begin
                  mode_q <= WDTPM_PDOWN;
               end else if (wr && addr == WDTPM_POWER_CONTROL_ADDR && wdata[WDTPM_BIT_IDLE]) begin
                  mode_q <= WDTPM_IDLE;
               end
            end
            WDTPM_IDLE: begin
               if (any_irq) begin
                  mode_q <= WDTPM_RUN;
               end
            end
            WDTPM_PDOWN: begin
               if (pd_wake) begin
                  mode_q <= WDTPM_RUN;
               end
            end
            default: mode_q <= WDTPM_RUN;
         endcase
      end
   end

   // power control: mode bits clear on exit; bit 4 survives all but power-on
   always_ff @(posedge clk) begin
      if (rst) begin
         power_control_q <= 8'h00;
      end else if (sreset) begin
         power_control_q <= power_control_q & (8'h01 << WDTPM_BIT_POWER_CONTROL_KEEP);
      end else if (wr && addr == WDTPM_POWER_CONTROL_ADDR) begin
         power_control_q <= wdata;
      end else if (mode_q != WDTPM_RUN && (any_irq || pd_wake)) begin
         power_control_q[WDTPM_BIT_PD] <= 1'b0;
         power_control_q[WDTPM_BIT_IDLE] <= 1'b0;
      end
   end

   // control register; restart bit self-clears one cycle after the write
   always_ff @(posedge clk) begin
      if (sreset) begin
         ctrl_q <= WDTPM_CTRL_RST;
      end else if (wr && addr == WDTPM_CTRL_ADDR) begin
         ctrl_q <= wdata & WDTPM_CTRL_WMASK;
      end else if (restart_pend) begin
         ctrl_q[WDTPM_BIT_RESTART] <= 1'b0;
      end
   end

   // prescaler and 14-bit timer; restart wins over counting
   always_ff @(posedge clk) begin
      if (sreset || restart_pend) begin
         presc_q <= 8'h00;
         timer_q <= '0;
      end else if (counting && mc_tick) begin
         presc_q <= presc_tc ? 8'h00 : presc_q + 8'h01;
         if (presc_tc) begin
            timer_q <= timer_q + WDTPM_TIMER_W'(1);
         end
      end
   end

   // overflow of the timer while enabled forces one reset pulse
   always_ff @(posedge clk) begin
      if (rst || wdog_fire_q) begin
         wdog_fire_q <= 1'b0;
      end else begin
         wdog_fire_q <= counting && mc_tick && presc_tc && (&timer_q) && !restart_pend;
      end
   end

   // register read port, data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            WDTPM_CTRL_ADDR: rdata <= ctrl_q;
            WDTPM_POWER_CONTROL_ADDR: rdata <= power_control_q;
            WDTPM_STAT_ADDR: rdata <= timer_q[WDTPM_TIMER_W-1:WDTPM_TIMER_W-8];
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // assertion helper: machine cycles counted since the timer last started from zero,
   // only meaningful while the ratio has not been changed in mid-count
   always_ff @(posedge clk) begin
      if (sreset || restart_pend) begin
         span_q <= 24'h000000;
         span_valid_q <= 1'b1;
      end else begin
         if (counting && mc_tick) begin
            span_q <= span_q + 24'h000001;
         end
         if (wr && addr == WDTPM_CTRL_ADDR && wdata[2:0] != ctrl_q[2:0]) begin
            span_valid_q <= 1'b0;
         end
      end
   end

   // reset clears run enable and counts
   reset_clears_a: assert property (@(posedge clk) sreset |=>
      (ctrl_q == 8'h00 && timer_q == '0 && presc_q == 8'h00))
      else $error("reset left watchdog state");
   disabled_quiet_a: assert property (@(posedge clk) disable iff (rst)
      !ctrl_q[WDTPM_BIT_RUN] && !sreset |=> !wdog_fire_q)
      else $error("disabled watchdog fired");
   restart_clears_a: assert property (@(posedge clk) disable iff (rst)
      restart_pend |=> (!restart_pend || $past(wr)) && timer_q == '0)
      else $error("restart bit did not clear");
   idle_hold_a: assert property (@(posedge clk) disable iff (sreset)
      mode_q == WDTPM_IDLE && !ctrl_q[WDTPM_BIT_IDLE_RUN] && !restart_pend |=> $stable(timer_q))
      else $error("watchdog counted in idle");
   pdown_halt_a: assert property (@(posedge clk) disable iff (sreset)
      mode_q == WDTPM_PDOWN && !restart_pend |=> $stable(timer_q) && $stable(presc_q))
      else $error("watchdog ran in power-down");
   fire_reset_a: assert property (@(posedge clk) disable iff (rst)
      wdog_fire_q |-> sys_reset ##1 (ctrl_q == 8'h00 && mode_q == WDTPM_RUN))
      else $error("time-out did not reset");
   pin_filter_a: assert property (@(posedge clk) disable iff (rst)
      $rose(pin_reset_q) && clocks_on |-> pin_cnt_q == 2'(WDTPM_RST_HOLD_MC - 1))
      else $error("reset pin taken too early");
   idle_cpu_a: assert property (@(posedge clk) disable iff (rst)
      mode_q == WDTPM_IDLE |-> !cpu_clk_en && periph_clk_en)
      else $error("idle clock gating wrong");
   presc_step_a: assert property (@(posedge clk) disable iff (sreset)
      !mc_tick && !restart_pend |=> $stable(presc_q))
      else $error("prescaler moved off machine cycle");
   power_control_keep_a: assert property (@(posedge clk) disable iff (rst)
      sreset |=> power_control_q[WDTPM_BIT_POWER_CONTROL_KEEP] == $past(power_control_q[WDTPM_BIT_POWER_CONTROL_KEEP]))
      else $error("power control bit 4 lost");

   // fire lands exactly 2^14 times the ratio machine cycles after a fresh start
   interval_exact_a: assert property (@(posedge clk) disable iff (rst)
      wdog_fire_q && span_valid_q |->
      span_q == (24'(wdtpm_ratio_m1(ctrl_q[2:0])) + 24'h000001) << WDTPM_TIMER_W)
      else $error("time-out interval wrong");

   // idle and power-down are the only other legal modes
   mode_legal_a: assert property (@(posedge clk) disable iff (rst)
      mode_q inside {WDTPM_RUN, WDTPM_IDLE, WDTPM_PDOWN})
      else $error("power mode left its encoding");

   // run mode clocks everything
   run_gates_a: assert property (@(posedge clk) disable iff (rst)
      mode_q == WDTPM_RUN |-> cpu_clk_en && periph_clk_en)
      else $error("run mode clock gating wrong");

   // power-down stops every clock
   pdown_gates_a: assert property (@(posedge clk) disable iff (rst)
      mode_q == WDTPM_PDOWN |-> !cpu_clk_en && !periph_clk_en)
      else $error("power-down clock gating wrong");

   // any interrupt ends idle
   idle_exit_a: assert property (@(posedge clk) disable iff (rst)
      mode_q == WDTPM_IDLE && any_irq |=> mode_q == WDTPM_RUN)
      else $error("interrupt did not end idle");

   // an enabled port interrupt wakes power-down
   pdown_wake_a: assert property (@(posedge clk) disable iff (rst)
      mode_q == WDTPM_PDOWN && pd_wake |=> mode_q == WDTPM_RUN)
      else $error("port interrupt did not wake");

   // a restart write raises the restart bit
   restart_set_a: assert property (@(posedge clk) disable iff (rst)
      wr && addr == WDTPM_CTRL_ADDR && wdata[WDTPM_BIT_RESTART] && !sreset |=> restart_pend)
      else $error("restart write not taken");

   // restart bit lasts one cycle unless written again
   restart_drop_a: assert property (@(posedge clk) disable iff (sreset)
      restart_pend && !(wr && addr == WDTPM_CTRL_ADDR) |=> !restart_pend)
      else $error("restart bit stuck");

   // prescaler wraps at its terminal count
   presc_wrap_a: assert property (@(posedge clk) disable iff (sreset)
      counting && mc_tick && presc_tc |=> presc_q == 8'h00)
      else $error("prescaler did not wrap");

   // timer steps by one on each prescaler terminal count
   timer_step_a: assert property (@(posedge clk) disable iff (sreset)
      counting && mc_tick && presc_tc && !restart_pend |=>
      timer_q == $past(timer_q) + WDTPM_TIMER_W'(1))
      else $error("timer did not step");

   // time-out reset is a single pulse
   fire_pulse_a: assert property (@(posedge clk) disable iff (rst)
      wdog_fire_q |=> !wdog_fire_q)
      else $error("time-out pulse too long");

   // only an enabled watchdog may fire
   fire_enabled_a: assert property (@(posedge clk) disable iff (rst)
      wdog_fire_q |-> $past(ctrl_q[WDTPM_BIT_RUN]))
      else $error("time-out while disabled");

   // a disabled watchdog holds its timer
   counting_off_a: assert property (@(posedge clk) disable iff (sreset)
      !ctrl_q[WDTPM_BIT_RUN] && !restart_pend |=> $stable(timer_q))
      else $error("disabled timer moved");

   // pin reset only follows a high pin
   pin_glitch_a: assert property (@(posedge clk) disable iff (rst)
      $rose(pin_reset_q) |-> $past(ext_reset_pin))
      else $error("pin reset without pin");

   // a low sample of the pin ends the pin reset
   pin_release_a: assert property (@(posedge clk) disable iff (rst)
      pin_reset_q && sample_now && !ext_reset_pin |=> !pin_reset_q)
      else $error("pin reset did not end");

   // power-on loads zero into both registers
   regs_zero_a: assert property (@(posedge clk)
      rst |=> power_control_q == 8'h00 && ctrl_q == WDTPM_CTRL_RST)
      else $error("registers not zero after power-on");

   // read data stand only in the cycle after a read strobe
   read_idle_a: assert property (@(posedge clk) disable iff (rst)
      !rd |=> rdata == 8'h00)
      else $error("read data without strobe");

   // unused control bits never hold a one
   ctrl_unused_a: assert property (@(posedge clk) disable iff (rst)
      ctrl_q[4:3] == 2'h0)
      else $error("unused control bits set");
endmodule : wdtpm_top

// File: wdtpm_pkg.sv
// constants for the watchdog timer with power modes
package wdtpm_pkg;
   localparam logic [7:0] WDTPM_CTRL_ADDR = 8'h8f;   // watchdog_control
   localparam logic [7:0] WDTPM_POWER_CONTROL_ADDR = 8'h87;   // power_control
   localparam logic [7:0] WDTPM_STAT_ADDR = 8'h90;   // watchdog status (count view)
   localparam logic [7:0] WDTPM_CTRL_RST = 8'h00;
   localparam int WDTPM_BIT_RUN = 7;
   localparam int WDTPM_BIT_RESTART = 6;
   localparam int WDTPM_BIT_IDLE_RUN = 5;
   localparam int WDTPM_BIT_PD = 1;
   localparam int WDTPM_BIT_IDLE = 0;
   localparam int WDTPM_BIT_POWER_CONTROL_KEEP = 4;
   localparam logic [7:0] WDTPM_CTRL_WMASK = 8'he7; // bits 4 and 3 unused, read zero
   localparam int WDTPM_TIMER_W = 14;
   localparam int WDTPM_MACHINE_OSC = 12;            // oscillator periods per machine cycle
   localparam int WDTPM_RST_HOLD_MC = 2;             // machine cycles reset must be held
   localparam int WDTPM_SAMPLE_PHASE = 9;            // state 5 phase 2 within twelve phases
   typedef enum logic [1:0] {
      WDTPM_RUN = 2'b00,
      WDTPM_IDLE = 2'b01,
      WDTPM_PDOWN = 2'b10
   } wdtpm_mode_t;
endpackage : wdtpm_pkg

// File: wdtpm_top_tb.sv
// self-checking bench for the watchdog with power modes
module wdtpm_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import wdtpm_pkg::*;
   localparam int PH = 2; // short machine cycle keeps the time-out run brief
   logic clk = 0, rst = 1, pin = 0, irq = 0, wr = 0, rd = 0, seen;
   logic [7:0] wake = 8'h00, addr = 8'h00, wdata = 8'h00, d;
   logic sys_reset, cpu_en, per_en;
   logic [13:0] cnt, c0;
   int bad_count = 0, tests_run = 0, cyc = 0, t0;
   int ratio[8] = '{2, 8, 4, 16, 32, 64, 128, 256};
   always #12.5 clk = ~clk;
   always @(posedge clk) cyc++;
   wdtpm_top #(.PHASES(PH)) wdtpm_top_i (.clk(clk), .rst(rst), .ext_reset_pin(pin),
      .wake_irq(wake), .any_irq(irq), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(d), .sys_reset(sys_reset), .cpu_clk_en(cpu_en), .periph_clk_en(per_en),
      .wdog_count(cnt));
   // one comparison, four-state exact
   task automatic check(input logic [31:0] got, exp, input string m);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, v);
      @(posedge clk);
      addr <= a; wdata <= v; wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask : wr_reg
   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, exp, input string m);
      @(posedge clk);
      addr <= a; rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 check(d, exp, m);
   endtask : rd_chk
   // bounded wait for the timer to move
   task automatic wait_chg();
      c0 = cnt;
      for (int i = 0; i < 600 && cnt === c0; i++) begin
         @(posedge clk); #1;
      end
   endtask : wait_chg
   // bounded wait for a reset pulse, latched in seen
   task automatic watch(input int n);
      seen = 0;
      for (int i = 0; i < n && !seen; i++) begin
         @(posedge clk); #1 seen = (sys_reset === 1'b1);
      end
   endtask : watch
   task automatic t_reset();
      check(sys_reset, 1, "reset out");
      rst <= 0;
      rd_chk(WDTPM_CTRL_ADDR, 8'h00, "ctrl reset");
      rd_chk(WDTPM_POWER_CONTROL_ADDR, 8'h00, "power_control reset");
      rd_chk(8'h00, 8'h00, "unmapped");
      check(cnt, 0, "count reset");
   endtask : t_reset
   task automatic t_mask();
      wr_reg(WDTPM_CTRL_ADDR, 8'h3f);
      rd_chk(WDTPM_CTRL_ADDR, 8'h27, "ctrl fields");
      repeat (40) @(posedge clk);
      #1 check(cnt, 0, "stopped");
   endtask : t_mask
   // every code, measured between two steps of the timer
   task automatic t_ratio();
      for (int k = 0; k < 8; k++) begin
         wr_reg(WDTPM_CTRL_ADDR, 8'hc0 | 8'(k));
         repeat (3) @(posedge clk);
         wait_chg();
         t0 = cyc;
         wait_chg();
         check(cyc - t0, ratio[k] * PH, "step period");
      end
   endtask : t_ratio
   task automatic t_restart();
      wr_reg(WDTPM_CTRL_ADDR, 8'h80);
      repeat (60) @(posedge clk);
      wr_reg(WDTPM_CTRL_ADDR, 8'hc0);
      @(posedge clk); #1;
      check(cnt, 0, "restart clears");
      rd_chk(WDTPM_CTRL_ADDR, 8'h80, "restart self clears");
   endtask : t_restart
   task automatic t_idle();
      wr_reg(WDTPM_CTRL_ADDR, 8'hc0);
      wr_reg(WDTPM_POWER_CONTROL_ADDR, 8'h01);
      #1 check({cpu_en, per_en}, 2'b01, "idle gates");
      c0 = cnt;
      repeat (40) @(posedge clk);
      #1 check(cnt, c0, "held in idle");
      @(posedge clk);
      irq <= 1;
      @(posedge clk) irq <= 0;
      repeat (2) @(posedge clk);
      #1 check(cpu_en, 1, "irq ends idle");
      wr_reg(WDTPM_CTRL_ADDR, 8'ha0);
      wr_reg(WDTPM_POWER_CONTROL_ADDR, 8'h01);
      c0 = cnt;
      repeat (40) @(posedge clk);
      #1 check(cnt !== c0, 1, "runs in idle");
      @(posedge clk);
      irq <= 1;
      @(posedge clk) irq <= 0;
   endtask : t_idle
   task automatic t_pdown();
      wr_reg(WDTPM_POWER_CONTROL_ADDR, 8'h02);
      #1 check({cpu_en, per_en}, 2'b00, "pd gates");
      c0 = cnt;
      repeat (40) @(posedge clk);
      #1 check(cnt, c0, "halted in pd");
      @(posedge clk);
      wake <= 8'h10;
      @(posedge clk) wake <= 8'h00;
      repeat (2) @(posedge clk);
      #1 check(per_en, 1, "wake");
   endtask : t_pdown
   task automatic t_pin();
      wr_reg(WDTPM_CTRL_ADDR, 8'ha5);
      pin <= 1;
      @(posedge clk) pin <= 0;
      watch(10);
      check(seen, 0, "glitch ignored");
      @(posedge clk);
      pin <= 1;
      watch(4 * PH + 4);
      check(seen, 1, "pin reset");
      @(posedge clk);
      pin <= 0;
      repeat (PH * 2) @(posedge clk);
      rd_chk(WDTPM_CTRL_ADDR, 8'h00, "ctrl after pin");
   endtask : t_pin
   // full interval at the shortest ratio, started by a restart write
   task automatic t_timeout();
      wr_reg(WDTPM_CTRL_ADDR, 8'hc0);
      t0 = cyc;
      watch(70000);
      check(seen, 1, "time-out reset");
      check((cyc - t0) > (65536 - 8) && (cyc - t0) < (65536 + 8), 1, "interval");
      rd_chk(WDTPM_CTRL_ADDR, 8'h00, "ctrl after fire");
      check(cnt, 0, "count after fire");
   endtask : t_timeout
   task automatic results();
      $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   initial begin
      repeat (2) @(posedge clk);
      t_reset(); t_mask(); t_ratio(); t_restart();
      t_idle(); t_pdown(); t_pin(); t_timeout();
      results();
   end
   // hang guard, well past the longest expected run
   initial begin
      #(100000 * 25);
      bad_count++;
      results();
   end
endmodule : wdtpm_top_tb
